// File: rtl/sgsc_pkg.sv
// package for the servo gain switchover controller: register map,
// reset values, write limits, time bases and the output carrier.
// assumes one 25 MHz core clock and an avalon-mm master with word addresses.
// Notes on behaviour
// [R1] blend 0..1000 per mille, default 1000
// [R2] speed feedforward select 0/1, applied on restart
// [R3] speed feedforward gain 0..1500, default 300
// [R4] speed feedforward filter 0..6400, default 50
// [R5] torque feedforward select 0..2, on restart
// [R6] torque feedforward gain 0..1000, filter 0..6400
// [R7] gain input: p/pi toggle or group swap
// [R8] modes 0 and 1 fix group 1/2
// [R9] mode 2 follows gain select input
// [R10] position mode 3: torque threshold with delay
// [R11] position mode 4 not applicable, group 1
// [R12] position mode 5: speed command threshold
// [R13] position mode 6: position deviation threshold
// [R14] position mode 7: command nonzero, delayed return
// [R15] position mode 8: positioning incomplete means group 2
// [R16] position mode 9: speed feedback threshold
// [R17] position mode 10: command zero and slow
// [R18] speed mode 3: torque threshold, speed delay
// [R19] speed mode 4: speed command variation threshold
// [R20] speed mode 5: speed command threshold
// [R21] torque mode 3: torque threshold, torque delay
// [R22] observer cutoff 0..500 hz, on restart
// [R23] rise above grade+hyst, release below grade-hyst
package sgsc_pkg;
  localparam int NCFG = 23;
  // word indices of the configuration registers
  localparam logic [4:0] A_BLEND = 5'h00, A_SFF_SEL = 5'h01;
  localparam logic [4:0] A_SFF_GAIN = 5'h02, A_SFF_FILT = 5'h03;
  localparam logic [4:0] A_TFF_SEL = 5'h04, A_TFF_GAIN = 5'h05;
  localparam logic [4:0] A_TFF_FILT = 5'h06, A_DI_FUNC = 5'h07;
  localparam logic [4:0] A_POS_MODE = 5'h08, A_POS_DELAY = 5'h09;
  localparam logic [4:0] A_POS_GRADE = 5'h0a, A_POS_HYST = 5'h0b;
  localparam logic [4:0] A_POS_TIME = 5'h0c, A_SPD_MODE = 5'h0d;
  localparam logic [4:0] A_SPD_DELAY = 5'h0e, A_SPD_GRADE = 5'h0f;
  localparam logic [4:0] A_SPD_HYST = 5'h10, A_TRQ_MODE = 5'h11;
  localparam logic [4:0] A_TRQ_DELAY = 5'h12, A_TRQ_GRADE = 5'h13;
  localparam logic [4:0] A_TRQ_HYST = 5'h14, A_OBS_EN = 5'h15;
  localparam logic [4:0] A_OBS_CUT = 5'h16, A_RESTART = 5'h17;
  localparam logic [4:0] A_STATUS = 5'h18;
  // values after reset, in register order
  localparam logic [15:0] CFG_DEF [NCFG] = '{
    16'h03e8, 16'h0000, 16'h012c, 16'h0032, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0032, 16'h0021,
    16'h0021, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064};
  // largest value each register accepts; larger writes saturate
  localparam logic [15:0] CFG_MAX [NCFG] = '{
    16'h03e8, 16'h0001, 16'h05dc, 16'h1900, 16'h0002, 16'h03e8,
    16'h1900, 16'h0001, 16'h000a, 16'h03e8, 16'h4e20, 16'h4e20,
    16'h03e8, 16'h0005, 16'h03e8, 16'h4e20, 16'h4e20, 16'h0003,
    16'h03e8, 16'h4e20, 16'h4e20, 16'h0002, 16'h01f4};
  // switchover delays count in 0.1 ms steps
  localparam int CLK_NS = 40;
  localparam int DELAY_STEP_NS = 100000;
  localparam int STEP_CYCLES = DELAY_STEP_NS / CLK_NS;
  localparam logic [11:0] STEP_LAST = 12'(STEP_CYCLES - 1);
  // control modes as presented on ctrl_mode
  localparam logic [1:0] CM_POS = 2'h0, CM_SPD = 2'h1, CM_TRQ = 2'h2;
  typedef enum {K_G1, K_G2, K_DI, K_THR, K_CMD, K_DONE, K_CMDFB}
    sgsc_kind_t;
  typedef struct packed {
    logic [15:0] blend;
    logic sff_on;
    logic [15:0] sff_gain;
    logic [15:0] sff_filt;
    logic [1:0] tff_sel;
    logic [15:0] tff_gain;
    logic [15:0] tff_filt;
    logic [1:0] obs_en;
    logic [15:0] obs_cut;
    logic group2;
    logic p_only;
  } sgsc_loop_cfg_t;
endpackage

// File: rtl/sgsc_hold_timer.sv
// return-delay timer for the gain switchover: counts delay steps while
// the release condition holds. assumes a one-cycle step pulse.
`timescale 1ns/1ps
module sgsc_hold_timer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic step,
  input wire logic run,
  input wire logic [15:0] delay,
  output logic expired
);
  logic [15:0] count;

  // restart from zero whenever the release condition breaks
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 16'h0000;
    end else if (!run) begin
      count <= 16'h0000;
    end else if (step && count < delay) begin
      count <= count + 16'h0001;
    end
  end

  // a zero delay expires on the cycle after the release begins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (count >= delay);
    end
  end
endmodule

// File: rtl/sgsc_ctrl.sv
// servo gain switchover controller: avalon-mm register file, restart
// shadows for restart-effective settings, and gain group selection.
// assumes quantities from core logic on core_clk, pins asynchronous.
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module sgsc_ctrl
  import sgsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] ctrl_mode,
  input wire logic gain_sel_pin,
  input wire logic pos_done_pin,
  input wire logic signed [15:0] torque_cmd,
  input wire logic signed [15:0] speed_cmd,
  input wire logic signed [15:0] speed_var,
  input wire logic signed [15:0] speed_fb,
  input wire logic signed [31:0] pos_dev,
  input wire logic signed [31:0] pos_cmd,
  output sgsc_loop_cfg_t loop_cfg
);
  logic [15:0] cfg [NCFG];
  logic act_sff;
  logic [1:0] act_tff;
  logic [1:0] act_obs_en;
  logic [15:0] act_obs_cut;
  logic group2;
  logic p_only;
  logic next_group2;
  logic next_p_only;
  logic gsel_m, gsel_s, done_m, done_s;
  logic [11:0] step_cnt;
  logic step;
  logic hit_w;
  logic restart_hit;
  logic [31:0] rd_val;
  sgsc_kind_t kind;
  logic [15:0] dly_v, grade_v, hyst_v;
  logic [31:0] mag_v;
  logic [16:0] rise_lvl;
  logic [15:0] fall_lvl;
  logic hi, rel, run, expired;

  function automatic logic [31:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 32'(-17'(v)) : 32'(v);
  endfunction

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // two flops on each pin; only the second stage is read
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gsel_m <= 1'b0;
      gsel_s <= 1'b0;
      done_m <= 1'b0;
      done_s <= 1'b0;
    end else begin
      gsel_m <= gain_sel_pin;
      gsel_s <= gsel_m;
      done_m <= pos_done_pin;
      done_s <= done_m;
    end
  end

  // one pulse per delay step
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step_cnt <= 12'h000;
      step <= 1'b0;
    end else begin
      step <= (step_cnt == STEP_LAST);
      step_cnt <= (step_cnt == STEP_LAST) ? 12'h000 : step_cnt + 12'h001;
    end
  end

  // bus handshake: first cycle drops waitrequest, the next edge completes
  assign hit_w = avs_write && !avs_waitrequest;
  assign restart_hit = hit_w && avs_address == A_RESTART
    && avs_writedata[0];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped words and reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (avs_address < 5'(NCFG)) begin
      rd_val = {16'h0000, cfg[avs_address]};
    end else if (avs_address == A_STATUS) begin
      rd_val = {16'h0000, act_obs_cut[8:0], act_obs_en, act_tff,
                act_sff, p_only, group2};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_val;
    end
  end

  // configuration store; writes beyond a register's range saturate
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg[i] <= CFG_DEF[i];
      end
    end else if (hit_w && avs_address < 5'(NCFG)) begin
      for (int i = 0; i < NCFG; i++) begin
        if (avs_address == 5'(i)) begin
          cfg[i] <= (avs_writedata[31:16] != 16'h0000
                     || avs_writedata[15:0] > CFG_MAX[i]) ?
                    CFG_MAX[i] : avs_writedata[15:0]; // R1 R3 R4 R6
        end
      end
    end
  end

  // restart-effective settings take the stored value only on restart
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      act_sff <= CFG_DEF[A_SFF_SEL][0];
      act_tff <= CFG_DEF[A_TFF_SEL][1:0];
      act_obs_en <= CFG_DEF[A_OBS_EN][1:0];
      act_obs_cut <= CFG_DEF[A_OBS_CUT];
    end else if (restart_hit) begin
      act_sff <= cfg[A_SFF_SEL][0]; // R2
      act_tff <= cfg[A_TFF_SEL][1:0]; // R5
      act_obs_en <= cfg[A_OBS_EN][1:0];
      act_obs_cut <= cfg[A_OBS_CUT]; // R22
    end
  end

  // pick the selector kind and its parameters for the active mode
  always_comb begin
    kind = K_G1;
    dly_v = cfg[A_POS_DELAY];
    grade_v = cfg[A_POS_GRADE];
    hyst_v = cfg[A_POS_HYST];
    mag_v = mag16(torque_cmd);
    unique case (ctrl_mode)
      CM_POS: begin
        unique case (cfg[A_POS_MODE])
          16'h0000: kind = K_G1; // R8
          16'h0001: kind = K_G2; // R8
          16'h0002: kind = K_DI; // R9
          16'h0003: kind = K_THR; // R10
          16'h0004: kind = K_G1; // R11
          16'h0005: begin
            kind = K_THR; // R12
            mag_v = mag16(speed_cmd);
          end
          16'h0006: begin
            kind = K_THR; // R13
            mag_v = mag32(pos_dev);
          end
          16'h0007: kind = K_CMD; // R14
          16'h0008: kind = K_DONE; // R15
          16'h0009: begin
            kind = K_THR; // R16
            mag_v = mag16(speed_fb);
          end
          16'h000a: begin
            kind = K_CMDFB; // R17
            mag_v = mag16(speed_fb);
          end
          default: kind = K_G1;
        endcase
      end
      CM_SPD: begin
        dly_v = cfg[A_SPD_DELAY];
        grade_v = cfg[A_SPD_GRADE];
        hyst_v = cfg[A_SPD_HYST];
        unique case (cfg[A_SPD_MODE])
          16'h0000: kind = K_G1;
          16'h0001: kind = K_G2;
          16'h0002: kind = K_DI;
          16'h0003: kind = K_THR; // R18
          16'h0004: begin
            kind = K_THR; // R19
            mag_v = mag16(speed_var);
          end
          16'h0005: begin
            kind = K_THR; // R20
            mag_v = mag16(speed_cmd);
          end
          default: kind = K_G1;
        endcase
      end
      CM_TRQ: begin
        dly_v = cfg[A_TRQ_DELAY];
        grade_v = cfg[A_TRQ_GRADE];
        hyst_v = cfg[A_TRQ_HYST];
        unique case (cfg[A_TRQ_MODE])
          16'h0000: kind = K_G1;
          16'h0001: kind = K_G2;
          16'h0002: kind = K_DI;
          16'h0003: kind = K_THR; // R21
          default: kind = K_G1;
        endcase
      end
      default: kind = K_G1;
    endcase
  end

  // hysteresis band; the lower edge floors at zero
  assign rise_lvl = {1'b0, grade_v} + {1'b0, hyst_v};
  assign fall_lvl = (grade_v > hyst_v) ? grade_v - hyst_v : 16'h0000;

  // next group and regulator form
  always_comb begin
    next_group2 = group2;
    next_p_only = 1'b0;
    hi = 1'b0;
    rel = 1'b0;
    unique case (kind)
      K_G1: next_group2 = 1'b0;
      K_G2: next_group2 = 1'b1;
      K_DI: begin
        if (cfg[A_DI_FUNC][0]) begin
          next_group2 = gsel_s; // R7
        end else begin
          next_group2 = 1'b0;
          next_p_only = gsel_s; // R7
        end
      end
      K_THR: begin
        hi = mag_v > 32'(rise_lvl); // R23
        rel = mag_v < 32'(fall_lvl); // R23
      end
      K_CMD: begin
        hi = pos_cmd != 32'h0000_0000;
        rel = !hi;
      end
      K_DONE: begin
        hi = !done_s;
        rel = done_s;
      end
      K_CMDFB: begin
        hi = pos_cmd != 32'h0000_0000;
        rel = !hi && mag_v < 32'(grade_v);
      end
    endcase
    if (hi) begin
      next_group2 = 1'b1;
    end else if (rel && expired) begin
      next_group2 = 1'b0;
    end
  end

  // the timer only runs while group 2 waits to be released
  assign run = rel && group2;

  sgsc_hold_timer u_hold (
    .core_clk(core_clk),
    .reset(reset),
    .step(step),
    .run(run),
    .delay(dly_v),
    .expired(expired)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      group2 <= 1'b0;
      p_only <= 1'b0;
    end else begin
      group2 <= next_group2;
      p_only <= next_p_only;
    end
  end

  // registered carrier to the loops; one cycle behind the decision
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      loop_cfg <= '0;
    end else begin
      loop_cfg.blend <= cfg[A_BLEND]; // R1
      loop_cfg.sff_on <= act_sff; // R2
      loop_cfg.sff_gain <= cfg[A_SFF_GAIN]; // R3
      loop_cfg.sff_filt <= cfg[A_SFF_FILT]; // R4
      loop_cfg.tff_sel <= act_tff; // R5
      loop_cfg.tff_gain <= cfg[A_TFF_GAIN]; // R6
      loop_cfg.tff_filt <= cfg[A_TFF_FILT]; // R6
      loop_cfg.obs_en <= act_obs_en;
      loop_cfg.obs_cut <= act_obs_cut; // R22
      loop_cfg.group2 <= group2;
      loop_cfg.p_only <= p_only;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_blend_range: assert property (cfg[A_BLEND] <= 16'h03e8) // R1
    else $error("blend above 1000");
  chk_sff_restart: assert property ( // R2
    !$stable(act_sff) |-> $past(restart_hit))
    else $error("speed ff select changed without restart");
  chk_sff_gain: assert property (cfg[A_SFF_GAIN] <= 16'h05dc) // R3
    else $error("speed ff gain out of range");
  chk_filt_range: assert property ( // R4
    cfg[A_SFF_FILT] <= 16'h1900 && cfg[A_TFF_FILT] <= 16'h1900)
    else $error("feedforward filter out of range");
  chk_tff_restart: assert property ( // R5
    !$stable(act_tff) |-> $past(restart_hit))
    else $error("torque ff select changed without restart");
  chk_tff_gain: assert property ( // R6
    cfg[A_TFF_GAIN] <= 16'h03e8 && act_tff <= 2'h2)
    else $error("torque ff setting out of range");
  chk_di_pi: assert property ( // R7
    kind == K_DI && !cfg[A_DI_FUNC][0] |=> !group2 && p_only == $past(gsel_s))
    else $error("p/pi toggle wrong");
  chk_fixed_group: assert property ( // R8
    kind == K_G2 |=> group2 ##1 loop_cfg.group2)
    else $error("fixed group 2 not applied");
  chk_pos_na: assert property ( // R11
    ctrl_mode == CM_POS && cfg[A_POS_MODE] == 16'h0004 |=> !group2)
    else $error("position mode 4 selected group 2");
  chk_thr_rise: assert property (hi |=> group2) // R23
    else $error("group 2 not taken above threshold");
  chk_no_early_drop: assert property ( // R14
    $fell(group2) && $past(kind) != K_G1 && $past(kind) != K_DI
    |-> $past(expired) && $past(rel))
    else $error("group 1 returned before delay");
  chk_obs_cut: assert property (act_obs_cut <= 16'h01f4) // R22
    else $error("observer cutoff out of range");

  cov_rise: cover property ($rose(group2));
  cov_fall: cover property ($fell(group2) && kind == K_THR);
  cov_restart: cover property (restart_hit);
  cov_cmdfb: cover property (kind == K_CMDFB && $fell(group2));
endmodule

// File: test/sgsc_motion_model.sv
// motion-side model: drives one chosen command or feedback quantity to a
// level and the rest to zero. assumes the bench picks quantity and level.
`timescale 1ns/1ps
module sgsc_motion_model (
  input wire logic core_clk,
  input wire logic [2:0] qsel,
  input wire logic signed [15:0] level,
  output logic signed [15:0] torque_cmd,
  output logic signed [15:0] speed_cmd,
  output logic signed [15:0] speed_var,
  output logic signed [15:0] speed_fb,
  output logic signed [31:0] pos_dev,
  output logic signed [31:0] pos_cmd,
  output logic pos_done_pin
);
  // quiet motor at time zero, so no input starts unknown
  initial begin
    {torque_cmd, speed_cmd, speed_var, speed_fb} = '0;
    {pos_dev, pos_cmd} = '0;
    pos_done_pin = 1'b1;
  end

  // 0 torque 1 speed cmd 2 speed change 3 speed fb 4 deviation
  // 5 position cmd 6 positioning (nonzero level means still moving)
  always @(posedge core_clk) begin
    torque_cmd <= (qsel == 3'h0) ? level : 16'sh0000;
    speed_cmd <= (qsel == 3'h1) ? level : 16'sh0000;
    speed_var <= (qsel == 3'h2) ? level : 16'sh0000;
    speed_fb <= (qsel == 3'h3) ? level : 16'sh0000;
    pos_dev <= (qsel == 3'h4) ? 32'(level) : 32'sh00000000;
    pos_cmd <= (qsel == 3'h5) ? 32'(level) : 32'sh00000000;
    pos_done_pin <= !(qsel == 3'h6 && level != 16'sh0000);
  end
endmodule

// File: test/test_servo_gain_switchover_ctrl.sv
// bench for the gain switchover controller: register checks over avalon,
// then group choice per control mode. assumes the motion model beside it.
`timescale 1ns/1ps
module test_servo_gain_switchover_ctrl;
  import sgsc_pkg::*;
  localparam int W = $bits(sgsc_loop_cfg_t);
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  logic [1:0] ctrl_mode = 2'h0;
  logic gain_sel_pin = 1'b0;
  logic [2:0] qsel = 3'h7;
  logic signed [15:0] level = 16'sh0000;
  logic signed [15:0] torque_cmd, speed_cmd, speed_var, speed_fb;
  logic signed [31:0] pos_dev, pos_cmd;
  logic pos_done_pin;
  sgsc_loop_cfg_t loop_cfg, ecfg;
  int mismatches = 0;
  int n_compared = 0;
  int n;
  // mode word per control mode; delay, grade, hysteresis follow it
  logic [4:0] ma [3] = '{A_POS_MODE, A_SPD_MODE, A_TRQ_MODE};
  // threshold cases: control mode, mode value, quantity, group 2 expected
  int t_cm [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 2};
  int t_mv [12] = '{3, 4, 5, 6, 7, 8, 9, 10, 3, 4, 5, 3};
  int t_q [12] = '{0, 0, 1, 4, 5, 6, 3, 5, 0, 2, 1, 0};
  int t_e [12] = '{1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};

  always #20 core_clk = ~core_clk;

  sgsc_ctrl i_dut (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ctrl_mode,
    .gain_sel_pin, .pos_done_pin, .torque_cmd, .speed_cmd, .speed_var,
    .speed_fb, .pos_dev, .pos_cmd, .loop_cfg);

  sgsc_motion_model i_motion (.core_clk, .qsel, .level, .torque_cmd,
    .speed_cmd, .speed_var, .speed_fb, .pos_dev, .pos_cmd, .pos_done_pin);

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [W-1:0] e, g);
    n_compared++;
    if (e !== g) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // one transfer; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk("waitrequest", W'(0), W'(avs_waitrequest));
      complete_run();
    end
  endtask

  // bounded wait on group2 (pon=0) or p_only (pon=1); k gives the cycles
  task automatic wait_cfg(input bit pon, input logic e, input int lim,
                          output int k);
    k = 0;
    while ((pon ? loop_cfg.p_only : loop_cfg.group2) !== e && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    chk(pon ? "p_only" : "group2", W'(e),
        W'(pon ? loop_cfg.p_only : loop_cfg.group2));
    // a wait that used up its bound ends the run
    if (lim > 0 && (pon ? loop_cfg.p_only : loop_cfg.group2) !== e) begin
      complete_run();
    end
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    ecfg = '0;
    ecfg.blend = 16'h03e8;
    ecfg.sff_gain = 16'h012c;
    ecfg.sff_filt = 16'h0032;
    ecfg.obs_cut = 16'h0064;
    chk("loop_cfg after reset", ecfg, loop_cfg);
    $display("test defaults done");
    // one above every limit must read back as the limit
    for (int i = 0; i < NCFG; i++) begin
      bus(1'b1, 5'(i), 32'(CFG_MAX[i]) + 32'h00000001);
      bus(1'b0, 5'(i), 32'h00000000);
      chk("saturated word", W'(CFG_MAX[i]), W'(rd));
    end
    bus(1'b1, 5'h1f, 32'h0000ffff);
    bus(1'b0, 5'h1f, 32'h00000000);
    chk("unmapped word", W'(0), W'(rd));
    repeat (3) @(posedge core_clk);
    chk("gains now", W'({16'h03e8, 16'h05dc, 16'h1900}),
        W'({loop_cfg.blend, loop_cfg.sff_gain, loop_cfg.sff_filt}));
    chk("ff gains now", W'({16'h03e8, 16'h1900}),
        W'({loop_cfg.tff_gain, loop_cfg.tff_filt}));
    chk("before restart", W'({1'b0, 2'h0, 2'h0, 16'h0064}),
        W'({loop_cfg.sff_on, loop_cfg.tff_sel, loop_cfg.obs_en,
        loop_cfg.obs_cut}));
    bus(1'b1, A_RESTART, 32'h00000001);
    repeat (3) @(posedge core_clk);
    chk("after restart", W'({1'b1, 2'h2, 2'h2, 16'h01f4}),
        W'({loop_cfg.sff_on, loop_cfg.tff_sel, loop_cfg.obs_en,
        loop_cfg.obs_cut}));
    // status packs the active set; group 1, pi regulator
    bus(1'b0, A_STATUS, 32'h00000000);
    chk("status word", W'(32'h0000fa54), W'(rd));
    $display("test limits and restart done");
    // reset in mid-run brings every word back to its start value
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < NCFG; i++) begin
      bus(1'b0, 5'(i), 32'h00000000);
      chk("reset word", W'(CFG_DEF[i]), W'(rd));
    end
    chk("loop_cfg after mid-run reset", ecfg, loop_cfg);
    $display("test reset values done");
    for (int m = 0; m < 3; m++) begin
      ctrl_mode <= 2'(m);
      bus(1'b1, ma[m], 32'h00000001);
      wait_cfg(0, 1'b1, 20, n);
      bus(1'b1, ma[m], 32'h00000000);
      wait_cfg(0, 1'b0, 20, n);
    end
    $display("test fixed groups done");
    ctrl_mode <= CM_POS;
    bus(1'b1, A_POS_MODE, 32'h00000002);
    bus(1'b1, A_DI_FUNC, 32'h00000001);
    gain_sel_pin <= 1'b1;
    wait_cfg(0, 1'b1, 20, n);
    bus(1'b1, A_DI_FUNC, 32'h00000000);
    wait_cfg(0, 1'b0, 20, n);
    wait_cfg(1, 1'b1, 20, n);
    gain_sel_pin <= 1'b0;
    wait_cfg(1, 1'b0, 20, n);
    $display("test gain input done");
    // zero delay, grade 100, hysteresis 10; the level is negative on purpose
    for (int i = 0; i < 12; i++) begin
      ctrl_mode <= 2'(t_cm[i]);
      bus(1'b1, ma[t_cm[i]] + 5'h01, 32'h00000000);
      bus(1'b1, ma[t_cm[i]] + 5'h02, 32'h00000064);
      bus(1'b1, ma[t_cm[i]] + 5'h03, 32'h0000000a);
      bus(1'b1, ma[t_cm[i]], 32'(t_mv[i]));
      qsel <= 3'(t_q[i]);
      level <= 16'shff38;
      wait_cfg(0, t_e[i][0], 40, n);
      repeat (20) @(posedge core_clk);
      wait_cfg(0, t_e[i][0], 0, n);
      level <= 16'sh0000;
      wait_cfg(0, 1'b0, 40, n);
    end
    $display("test thresholds done");
    ctrl_mode <= CM_POS;
    bus(1'b1, A_POS_MODE, 32'h00000003);
    bus(1'b1, A_POS_DELAY, 32'h00000002);
    bus(1'b1, A_POS_GRADE, 32'h00000032);
    bus(1'b1, A_POS_HYST, 32'h00000021);
    qsel <= 3'h0;
    level <= 16'sh0053;
    repeat (20) @(posedge core_clk);
    wait_cfg(0, 1'b0, 0, n);
    level <= 16'shffac;
    wait_cfg(0, 1'b1, 40, n);
    level <= 16'sh0011;
    repeat (6000) @(posedge core_clk);
    wait_cfg(0, 1'b1, 0, n);
    level <= 16'sh0010;
    wait_cfg(0, 1'b0, 6000, n);
    chk("return delay", W'(1), W'(n >= 2490 && n <= 5020));
    $display("test delay done");
    complete_run();
  end
endmodule
